// *** src/dsal_top.sv ***
// data store access control and flash security lock
//
// Summary of operation
// R1: erase-prohibit and boot-rewrite-prohibit, once set, are never cleared.
// R2: write-prohibit release refused in self-programming; only serial may release.
// R3: release needs no erase/boot prohibit and both flash areas blank.
// R4: all three prohibitions may be set by serial or self-programming.
// R5: data store erase works on whole one-kilobyte blocks.
// R6: data store accesses are byte wide only; wider ones refused.
// R7: cpu reads return data store bytes once enabled and set up.
// R8: instruction fetch from the data store range is refused.
// R9: code fetch continues while a background data store rewrite runs.
// R10: data store access blocked during code flash self-programming rewrite.
// R11: control register writes ignored while data store rewrite runs.
// R12: stop entry refused while a data store rewrite runs.
// R13: control register resets to zero, data store stopped.
// R14: bit 0 is access enable; bits 7 to 1 read zero.
// R15: control register accepts single-bit and whole-byte writes.
// R16: data store inaccessible for mode-dependent setup time after enable.
// R17: software clears enable before stop during setup time.
// R18: software keeps fast oscillator running, waits 30 us after restart.
// R19: boot region 00000h to 00fffh refuses erase and write when protected.
// R20: write-prohibit refuses serial writes, allows self-programming writes.
// R21: setup delay counter loads on enable rise, clears on fall.
`default_nettype none
module dsal_top (
   input  wire logic                        clk,
   input  wire logic                        rst_n,
   input  wire dsal_pkg::dsal_mode_type     main_mode,
   input  wire dsal_pkg::dsal_cpu_req_type  cpu_req,
   output logic [7:0]                       cpu_rdata,
   output logic                             cpu_rvalid,
   output logic                             cpu_refused,
   output logic                             df_rd_en,
   output logic [19:0]                      df_addr,
   input  wire logic [7:0]                  df_rdata,
   input  wire logic                        code_rewrite_busy,
   input  wire logic                        background_rewrite,
   input  wire logic                        code_area_blank,
   input  wire logic                        data_area_blank,
   input  wire dsal_pkg::dsal_sec_req_type  sec_req,
   output logic                             sec_ack,
   output logic                             sec_nak,
   output dsal_pkg::dsal_sec_type           sec_state,
   input  wire dsal_pkg::dsal_prog_cmd_type prog_cmd,
   output logic                             prog_go,
   output logic                             prog_nak,
   output logic [19:0]                      prog_addr,
   input  wire logic                        stop_req,
   output logic                             stop_grant,
   output logic                             access_ready
);
   import dsal_pkg::*;

   function automatic logic in_data_store(input logic [19:0] a);
      in_data_store = (a >= DSAL_DF_BASE) && (a <= DSAL_DF_LAST);
   endfunction : in_data_store

   logic           ctl_en_reg;
   logic           setup_done;
   dsal_state_type state_reg;
   dsal_state_type state_next;
   dsal_sec_type   sec_reg;
   logic [7:0]     cpu_rdata_reg;
   logic           cpu_rvalid_reg;
   logic           cpu_refused_reg;
   logic           sec_ack_reg;
   logic           sec_nak_reg;
   logic           prog_go_reg;
   logic           prog_nak_reg;
   logic [19:0]    prog_addr_reg;
   logic           stop_grant_reg;
   logic           ctl_hit;
   logic           df_hit;
   logic           df_ok;
   logic [7:0]     ctl_new;
   logic [7:0]     ctl_read;

   assign ctl_hit = cpu_req.valid && !cpu_req.fetch && (cpu_req.addr == DSAL_CTL_ADDR);
   assign df_hit  = cpu_req.valid && in_data_store(cpu_req.addr);
   // R14: upper bits fixed at zero
   assign ctl_read = {7'h00, ctl_en_reg};

   // R15: bit operation merges into current value
   always_comb begin
      ctl_new = cpu_req.wdata;
      if (cpu_req.bit_op) begin
         ctl_new = ctl_read;
         ctl_new[cpu_req.bit_sel] = cpu_req.wdata[0];
      end
   end

   // R13: cleared by reset
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctl_en_reg <= DSAL_CTL_RESET[DSAL_EN_BIT];
      // R11: locked during data store rewrite
      end else if (ctl_hit && cpu_req.write && !cpu_req.wide && !background_rewrite) begin
         ctl_en_reg <= ctl_new[DSAL_EN_BIT];
      end
   end

   dsal_setup_timer u_setup (
      .clk    (clk),
      .rst_n  (rst_n),
      .enable (ctl_en_reg),
      .mode   (main_mode),
      .done   (setup_done)
   );

   always_comb begin
      case (state_reg)
         DSAL_ST_OFF:   state_next = ctl_en_reg ? DSAL_ST_SETUP : DSAL_ST_OFF;
         DSAL_ST_SETUP: state_next = !ctl_en_reg ? DSAL_ST_OFF :
                                     (setup_done ? DSAL_ST_READY : DSAL_ST_SETUP);
         DSAL_ST_READY: state_next = ctl_en_reg ? DSAL_ST_READY : DSAL_ST_OFF;
         default:       state_next = DSAL_ST_OFF;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_reg <= DSAL_ST_OFF;
      end else begin
         state_reg <= state_next;
      end
   end

   assign access_ready = (state_reg == DSAL_ST_READY);

   // R8: no fetch from data range
   // R6: byte wide only
   // R10: blocked by code rewrite
   // R16: blocked during setup
   assign df_ok = df_hit && !cpu_req.fetch && !cpu_req.wide && !cpu_req.write
                  && !code_rewrite_busy && access_ready;
   // R7: direct cpu read of array
   assign df_rd_en = df_ok;
   assign df_addr  = cpu_req.addr;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cpu_rdata_reg   <= 8'h00;
         cpu_rvalid_reg  <= 1'b0;
         cpu_refused_reg <= 1'b0;
      end else begin
         cpu_rvalid_reg  <= 1'b0;
         cpu_refused_reg <= 1'b0;
         if (ctl_hit && !cpu_req.write) begin
            cpu_rdata_reg  <= ctl_read;
            cpu_rvalid_reg <= 1'b1;
         end else if (df_ok) begin
            cpu_rdata_reg  <= df_rdata;
            cpu_rvalid_reg <= 1'b1;
         end else if (df_hit) begin
            // R9: refusal touches only data range, code fetch unaffected
            cpu_rdata_reg   <= 8'h00;
            cpu_refused_reg <= 1'b1;
         end
      end
   end

   assign cpu_rdata   = cpu_rdata_reg;
   assign cpu_rvalid  = cpu_rvalid_reg;
   assign cpu_refused = cpu_refused_reg;

   // security bits live in this block; loss at reset stands in for option storage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sec_reg     <= '0;
         sec_ack_reg <= 1'b0;
         sec_nak_reg <= 1'b0;
      end else begin
         sec_ack_reg <= 1'b0;
         sec_nak_reg <= 1'b0;
         if (sec_req.valid) begin
            if (sec_req.release_write) begin
               // R2: self-programming may not release
               // R3: release only when clean and blank
               if (sec_req.serial && !sec_reg.erase_prohibit && !sec_reg.boot_prohibit
                   && code_area_blank && data_area_blank) begin
                  sec_reg.write_prohibit <= sec_req.set_write;
                  sec_ack_reg            <= 1'b1;
               end else begin
                  sec_nak_reg <= 1'b1;
               end
            end else begin
               // R4: either flow sets; R1: only ever ored in
               sec_reg.erase_prohibit <= sec_reg.erase_prohibit | sec_req.set_erase;
               sec_reg.write_prohibit <= sec_reg.write_prohibit | sec_req.set_write;
               sec_reg.boot_prohibit  <= sec_reg.boot_prohibit | sec_req.set_boot;
               sec_ack_reg            <= 1'b1;
            end
         end
      end
   end

   assign sec_state = sec_reg;
   assign sec_ack   = sec_ack_reg;
   assign sec_nak   = sec_nak_reg;

   function automatic logic prog_addr_in_boot(input logic [19:0] a);
      prog_addr_in_boot = (a >= DSAL_BOOT_FIRST) && (a <= DSAL_BOOT_LAST);
   endfunction : prog_addr_in_boot

   logic boot_hit;
   logic cmd_bad;
   assign boot_hit = !prog_cmd.on_data_store && (prog_addr_in_boot(prog_cmd.addr));

   always_comb begin
      cmd_bad = 1'b0;
      // R19: boot region guarded
      if (sec_reg.boot_prohibit && boot_hit && (prog_cmd.erase || prog_cmd.write)) begin
         cmd_bad = 1'b1;
      end
      // R20: write-prohibit only hits serial writes
      if (sec_reg.write_prohibit && prog_cmd.serial && prog_cmd.write
          && !prog_cmd.on_data_store) begin
         cmd_bad = 1'b1;
      end
      if (sec_reg.erase_prohibit && prog_cmd.serial && prog_cmd.erase
          && !prog_cmd.on_data_store) begin
         cmd_bad = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prog_go_reg   <= 1'b0;
         prog_nak_reg  <= 1'b0;
         prog_addr_reg <= 20'h00000;
      end else begin
         prog_go_reg  <= 1'b0;
         prog_nak_reg <= 1'b0;
         if (prog_cmd.valid) begin
            prog_go_reg  <= !cmd_bad;
            prog_nak_reg <= cmd_bad;
            // R5: data store erase aligned to whole block
            if (prog_cmd.erase && prog_cmd.on_data_store) begin
               prog_addr_reg <= {prog_cmd.addr[19:DSAL_ERASE_SHIFT],
                                 {DSAL_ERASE_SHIFT{1'b0}}};
            end else begin
               prog_addr_reg <= prog_cmd.addr;
            end
         end
      end
   end

   assign prog_go   = prog_go_reg;
   assign prog_nak  = prog_nak_reg;
   assign prog_addr = prog_addr_reg;

   // R12: stop held off during rewrite
   // R17: setup in progress also holds stop, so software clears enable first
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stop_grant_reg <= 1'b0;
      end else begin
         stop_grant_reg <= stop_req && !background_rewrite && (state_reg != DSAL_ST_SETUP);
      end
   end

   assign stop_grant = stop_grant_reg;
endmodule : dsal_top
`default_nettype wire

// *** src/dsal_pkg.sv ***
// package: constants and carrier types for the data store access and security lock block
`default_nettype none
package dsal_pkg;
   localparam logic [19:0] DSAL_CTL_ADDR     = 20'hf0090;
   localparam logic [7:0]  DSAL_CTL_RESET    = 8'h00;
   localparam int          DSAL_EN_BIT       = 0;
   localparam logic [19:0] DSAL_DF_BASE      = 20'hf1000;
   localparam logic [19:0] DSAL_DF_LAST      = 20'hf1fff;
   localparam logic [19:0] DSAL_BOOT_FIRST   = 20'h00000;
   localparam logic [19:0] DSAL_BOOT_LAST    = 20'h00fff;
   localparam int          DSAL_ERASE_BLOCK_BYTES = 1024;
   localparam int          DSAL_ERASE_SHIFT  = 10;
   localparam int          DSAL_CLK_MHZ      = 250;
   localparam int          DSAL_SETUP_HS_NS  = 5000;
   localparam int          DSAL_SETUP_LS_NS  = 720;
   localparam int          DSAL_SETUP_LV_NS  = 10000;
   localparam int          DSAL_HS_CYC = (DSAL_SETUP_HS_NS * DSAL_CLK_MHZ + 999) / 1000;
   localparam int          DSAL_LS_CYC = (DSAL_SETUP_LS_NS * DSAL_CLK_MHZ + 999) / 1000;
   localparam int          DSAL_LV_CYC = (DSAL_SETUP_LV_NS * DSAL_CLK_MHZ + 999) / 1000;
   localparam int          DSAL_CNT_W  = 12;

   typedef enum logic [1:0] {
      DSAL_MODE_HS = 2'h0,
      DSAL_MODE_LS = 2'h1,
      DSAL_MODE_LV = 2'h2
   } dsal_mode_type;

   typedef enum logic [1:0] {
      DSAL_ST_OFF   = 2'h0,
      DSAL_ST_SETUP = 2'h1,
      DSAL_ST_READY = 2'h3
   } dsal_state_type;

   // cpu load/store access
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        fetch;
      logic        bit_op;
      logic [2:0]  bit_sel;
      logic        wide;
      logic [19:0] addr;
      logic [7:0]  wdata;
   } dsal_cpu_req_type;

   // programming flow command
   typedef struct packed {
      logic        valid;
      logic        serial;
      logic        erase;
      logic        write;
      logic        on_data_store;
      logic [19:0] addr;
   } dsal_prog_cmd_type;

   // security set/release request
   typedef struct packed {
      logic valid;
      logic serial;
      logic release_write;
      logic set_erase;
      logic set_write;
      logic set_boot;
   } dsal_sec_req_type;

   typedef struct packed {
      logic erase_prohibit;
      logic write_prohibit;
      logic boot_prohibit;
   } dsal_sec_type;
endpackage : dsal_pkg
`default_nettype wire

// *** src/dsal_setup_timer.sv ***
// setup delay counter for the data store power-up
`default_nettype none
module dsal_setup_timer (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  enable,
   input  wire dsal_pkg::dsal_mode_type mode,
   output logic                       done
);
   import dsal_pkg::*;

   logic [DSAL_CNT_W-1:0] count_reg;
   logic                  enable_d_reg;

   function automatic logic [DSAL_CNT_W-1:0] load_value(input dsal_mode_type m);
      case (m)
         DSAL_MODE_HS: load_value = DSAL_CNT_W'(DSAL_HS_CYC);
         DSAL_MODE_LS: load_value = DSAL_CNT_W'(DSAL_LS_CYC);
         DSAL_MODE_LV: load_value = DSAL_CNT_W'(DSAL_LV_CYC);
         default:      load_value = DSAL_CNT_W'(DSAL_LV_CYC);
      endcase
   endfunction : load_value

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         enable_d_reg <= 1'b0;
      end else begin
         enable_d_reg <= enable;
      end
   end

   // R21: load on rise, clear on fall
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         count_reg <= '0;
      end else if (!enable) begin
         count_reg <= '0;
      end else if (!enable_d_reg) begin
         count_reg <= load_value(mode);
      end else if (count_reg != '0) begin
         count_reg <= count_reg - DSAL_CNT_W'(1);
      end
   end

   // R16: held off until count runs out
   assign done = enable && enable_d_reg && (count_reg == '0);
endmodule : dsal_setup_timer
`default_nettype wire

// *** sim/dsal_monitor.sv ***
// concurrent checks on the ports of the data store access and security lock
`default_nettype none
module dsal_monitor
   import dsal_pkg::*;
(
   input wire logic                        clk,
   input wire logic                        rst_n,
   input wire dsal_pkg::dsal_cpu_req_type  cpu_req,
   input wire logic                        cpu_rvalid,
   input wire logic                        cpu_refused,
   input wire logic                        df_rd_en,
   input wire logic                        code_rewrite_busy,
   input wire logic                        background_rewrite,
   input wire logic                        code_area_blank,
   input wire logic                        data_area_blank,
   input wire dsal_pkg::dsal_sec_req_type  sec_req,
   input wire logic                        sec_ack,
   input wire logic                        sec_nak,
   input wire dsal_pkg::dsal_sec_type      sec_state,
   input wire dsal_pkg::dsal_prog_cmd_type prog_cmd,
   input wire logic                        prog_go,
   input wire logic                        prog_nak,
   input wire logic [19:0]                 prog_addr,
   input wire logic                        stop_grant,
   input wire logic                        access_ready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic df_hit;
   assign df_hit = cpu_req.valid && cpu_req.addr >= DSAL_DF_BASE && cpu_req.addr <= DSAL_DF_LAST;

   read_gate_a: assert property (
      df_rd_en |-> access_ready && !code_rewrite_busy && !cpu_req.fetch && !cpu_req.wide)
      else $error("data store read launched while blocked");
   fetch_refused_a: assert property (df_hit && cpu_req.fetch |=> cpu_refused && !cpu_rvalid)
      else $error("fetch from data store not refused");
   wide_refused_a: assert property (df_hit && cpu_req.wide |=> cpu_refused)
      else $error("wide data store access not refused");
   erase_sticky_a: assert property (sec_state.erase_prohibit |=> sec_state.erase_prohibit)
      else $error("erase prohibit cleared");
   boot_sticky_a: assert property ($past(sec_state.boot_prohibit) |-> sec_state.boot_prohibit)
      else $error("boot prohibit cleared");
   self_release_a: assert property (
      sec_req.valid && sec_req.release_write && !sec_req.serial |=> sec_nak && !sec_ack)
      else $error("self-programming release accepted");
   release_blank_a: assert property (
      sec_req.valid && sec_req.release_write && !(code_area_blank && data_area_blank)
      |=> sec_nak) else $error("release accepted with non-blank flash");
   stop_block_a: assert property (background_rewrite |=> !stop_grant)
      else $error("stop granted during rewrite");
   boot_guard_a: assert property (
      prog_cmd.valid && sec_state.boot_prohibit && !prog_cmd.on_data_store
      && (prog_cmd.erase || prog_cmd.write)
      && prog_cmd.addr <= DSAL_BOOT_LAST |=> prog_nak && !prog_go)
      else $error("boot region rewrite not refused");
   erase_floor_a: assert property (
      prog_cmd.valid && prog_cmd.erase && prog_cmd.on_data_store
      |=> prog_addr === {$past(prog_cmd.addr[19:10]), 10'h000})
      else $error("data store erase not block aligned");
   reset_clear_a: assert property ($rose(rst_n) |-> !access_ready && sec_state == 3'h0)
      else $error("state not cleared by reset");

   read_cov_c: cover property (df_rd_en ##1 cpu_rvalid);
   ack_cov_c: cover property (sec_req.valid && sec_req.release_write ##1 sec_ack);
   go_cov_c: cover property (prog_cmd.valid ##1 prog_go);
endmodule : dsal_monitor

bind dsal_top dsal_monitor u_dsal_monitor (
   .clk(clk), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_rvalid(cpu_rvalid),
   .cpu_refused(cpu_refused), .df_rd_en(df_rd_en), .code_rewrite_busy(code_rewrite_busy),
   .background_rewrite(background_rewrite), .code_area_blank(code_area_blank),
   .data_area_blank(data_area_blank), .sec_req(sec_req), .sec_ack(sec_ack),
   .sec_nak(sec_nak), .sec_state(sec_state), .prog_cmd(prog_cmd), .prog_go(prog_go),
   .prog_nak(prog_nak), .prog_addr(prog_addr), .stop_grant(stop_grant),
   .access_ready(access_ready)
);
`default_nettype wire

// *** sim/dsal_flash_model.sv ***
// behavioural data store array answering byte reads
`default_nettype none
module dsal_flash_model (
   input  wire logic        rd_en,
   input  wire logic [19:0] addr,
   output logic [7:0]       rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // byte answer; idle shows the inverse so stale data never matches
   // fast oscillator assumed running, rewrites never start cold
   assign rdata = rd_en ? (addr[7:0] ^ 8'h5a) : ~(addr[7:0] ^ 8'h5a);
endmodule : dsal_flash_model
`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for the data store access and security lock
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dsal_pkg::*;
   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   dsal_mode_type     mode = DSAL_MODE_HS;
   dsal_cpu_req_type  cpu_req = '0;
   dsal_sec_req_type  sec_req = '0;
   dsal_prog_cmd_type prog_cmd = '0;
   logic              busy = 1'b0, bg = 1'b0, cblank = 1'b0, dblank = 1'b0, stop_req = 1'b0;
   logic [7:0]        cpu_rdata, df_rdata;
   logic [19:0]       df_addr, prog_addr;
   logic              cpu_rvalid, cpu_refused, df_rd_en, sec_ack, sec_nak;
   logic              prog_go, prog_nak, stop_grant, ready;
   dsal_sec_type      sec_state;
   int                n_fail = 0, samples_checked = 0;

   dsal_top u_dsal_top (.clk(clk), .rst_n(rst_n), .main_mode(mode), .cpu_req(cpu_req),
      .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .cpu_refused(cpu_refused),
      .df_rd_en(df_rd_en), .df_addr(df_addr), .df_rdata(df_rdata),
      .code_rewrite_busy(busy), .background_rewrite(bg), .code_area_blank(cblank),
      .data_area_blank(dblank), .sec_req(sec_req), .sec_ack(sec_ack), .sec_nak(sec_nak),
      .sec_state(sec_state), .prog_cmd(prog_cmd), .prog_go(prog_go), .prog_nak(prog_nak),
      .prog_addr(prog_addr), .stop_req(stop_req), .stop_grant(stop_grant),
      .access_ready(ready));
   dsal_flash_model u_dsal_flash_model (.rd_en(df_rd_en), .addr(df_addr), .rdata(df_rdata));

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic chk(string what, logic [19:0] exp, logic [19:0] got);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic conclude();
      if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   // one-cycle request launched at a falling edge, answer sampled at the next
   task automatic cpu(logic w, logic f, logic wd, logic bo, logic [19:0] a, logic [7:0] d);
      cpu_req <= '{1'b1, w, f, bo, 3'h0, wd, a, d};
      @(negedge clk);
      cpu_req <= '0;
   endtask : cpu

   task automatic rd(logic [19:0] a, logic ok, logic [7:0] d);
      cpu(1'b0, 1'b0, 1'b0, 1'b0, a, 8'h00);
      chk("cpu_rvalid", ok, cpu_rvalid);
      chk("cpu_refused", !ok, cpu_refused);
      if (ok) chk("cpu_rdata", d, cpu_rdata);
   endtask : rd

   task automatic sec(logic s, logic rel, logic [2:0] set, logic ack);
      sec_req <= {1'b1, s, rel, set};
      @(negedge clk);
      sec_req <= '0;
      chk("sec_ack", ack, sec_ack);
      chk("sec_nak", !ack, sec_nak);
   endtask : sec

   task automatic prog(logic s, logic er, logic ds, logic [19:0] a, logic go);
      prog_cmd <= {1'b1, s, er, !er, ds, a};
      @(negedge clk);
      prog_cmd <= '0;
      chk("prog_go", go, prog_go);
      chk("prog_nak", !go, prog_nak);
   endtask : prog

   // bit clear, then byte enable; setup length counted in edges after the take
   task automatic setup(dsal_mode_type m, int n);
      int c;
      cpu(1'b1, 1'b0, 1'b0, 1'b1, DSAL_CTL_ADDR, 8'h00);
      mode <= m;
      @(negedge clk);
      chk("ready after clear", 1'b0, ready);
      cpu(1'b1, 1'b0, 1'b0, 1'b0, DSAL_CTL_ADDR, 8'hff);
      c = 0;
      while (!ready && c < 3000) begin
         @(negedge clk);
         c++;
      end
      chk("setup length ok", 1'b1, c >= n && c <= n + 2);
   endtask : setup

   initial begin
      repeat (20) @(negedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      rd(DSAL_CTL_ADDR, 1'b1, 8'h00);
      rd(20'hf1004, 1'b0, 8'h00);
      setup(DSAL_MODE_HS, DSAL_HS_CYC);
      setup(DSAL_MODE_LV, DSAL_LV_CYC);
      setup(DSAL_MODE_LS, DSAL_LS_CYC);
      rd(DSAL_CTL_ADDR, 1'b1, 8'h01);
      rd(20'hf1abc, 1'b1, 8'hbc ^ 8'h5a);
      cpu(1'b0, 1'b1, 1'b0, 1'b0, 20'hf1abc, 8'h00);
      chk("fetch refused", 1'b1, cpu_refused);
      cpu(1'b0, 1'b0, 1'b1, 1'b0, 20'hf1abc, 8'h00);
      chk("wide refused", 1'b1, cpu_refused);
      busy <= 1'b1;
      rd(20'hf1abc, 1'b0, 8'h00);
      busy <= 1'b0;
      bg <= 1'b1;
      stop_req <= 1'b1;
      cpu(1'b1, 1'b0, 1'b0, 1'b0, DSAL_CTL_ADDR, 8'h00);
      rd(DSAL_CTL_ADDR, 1'b1, 8'h01);
      chk("stop_grant", 1'b0, stop_grant);
      bg <= 1'b0;
      repeat (2) @(negedge clk);
      chk("stop_grant", 1'b1, stop_grant);
      cpu(1'b1, 1'b0, 1'b0, 1'b0, DSAL_CTL_ADDR, 8'h00);
      cpu(1'b1, 1'b0, 1'b0, 1'b0, DSAL_CTL_ADDR, 8'h01);
      repeat (2) @(negedge clk);
      chk("stop_grant in setup", 1'b0, stop_grant);
      cpu(1'b1, 1'b0, 1'b0, 1'b0, DSAL_CTL_ADDR, 8'h00);
      repeat (2) @(negedge clk);
      chk("stop_grant after clear", 1'b1, stop_grant);
      stop_req <= 1'b0;
      sec(1'b0, 1'b1, 3'b000, 1'b0);
      sec(1'b0, 1'b0, 3'b010, 1'b1);
      sec(1'b1, 1'b1, 3'b000, 1'b0);
      cblank <= 1'b1;
      dblank <= 1'b1;
      sec(1'b0, 1'b1, 3'b000, 1'b0);
      sec(1'b1, 1'b1, 3'b000, 1'b1);
      chk("sec_state", 3'b000, sec_state);
      sec(1'b1, 1'b0, 3'b010, 1'b1);
      prog(1'b1, 1'b0, 1'b0, 20'h02000, 1'b0);
      prog(1'b0, 1'b0, 1'b0, 20'h02000, 1'b1);
      prog(1'b1, 1'b1, 1'b0, 20'h02000, 1'b1);
      sec(1'b1, 1'b0, 3'b100, 1'b1);
      sec(1'b0, 1'b0, 3'b001, 1'b1);
      prog(1'b0, 1'b0, 1'b0, 20'h00fff, 1'b0);
      prog(1'b0, 1'b1, 1'b0, 20'h01000, 1'b1);
      sec(1'b1, 1'b1, 3'b000, 1'b0);
      chk("sec_state", 3'b111, sec_state);
      prog(1'b1, 1'b1, 1'b1, 20'hf1234, 1'b1);
      chk("prog_addr", 20'hf1000, prog_addr);
      conclude();
   end
endmodule : testbench
`default_nettype wire
